// File: hw/oss_cfg.svh
// named constants for the optical sensor serial port controller
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH
`define OSS_CLK_MHZ 100
`define OSS_CYC_MIN(ns) ((((ns) * `OSS_CLK_MHZ) + 999) / 1000)
`define OSS_CYC_MAX(ns) (((ns) * `OSS_CLK_MHZ) / 1000)
`define OSS_T_WR_GAP_NS 20000
`define OSS_T_WW_GAP_NS 20000
`define OSS_T_SRAD_MIN_NS 4000
`define OSS_T_SRAD_MAX_NS 10000
`define OSS_T_RD_GAP_NS 500
`define OSS_T_BEXIT_NS 250
`define OSS_T_SEL_SCK_NS 120
`define OSS_T_SCK_SEL_RD_NS 120
`define OSS_T_SCK_SEL_WR_NS 20000
`define OSS_T_HRST_NS 1000
`define OSS_WAKEUP_CYC 100000
`define OSS_SCK_HALF 8
`define OSS_BURST_LEN 7
`define OSS_OFF_CMD 12'h000
`define OSS_OFF_STATUS 12'h004
`define OSS_OFF_RDATA0 12'h008
`define OSS_OFF_RDATA1 12'h00C
`define OSS_CMD_W 21
`define OSS_CMD_ADDR_MSB 6
`define OSS_CMD_ADDR_LSB 0
`define OSS_CMD_WR 7
`define OSS_CMD_DATA_MSB 15
`define OSS_CMD_DATA_LSB 8
`define OSS_CMD_BURST 16
`define OSS_CMD_BLEN_MSB 19
`define OSS_CMD_BLEN_LSB 17
`define OSS_CMD_HRST 20
`define OSS_ST_BUSY 0
`define OSS_ST_PD 1
`define OSS_ST_WAKE 2
`define OSS_DEV_BURST_ADDR 7'h63
`define OSS_DEV_CTRL_ADDR 7'h0D
`define OSS_DEV_PD_BIT 1
`define OSS_DEV_RST_ADDR 7'h3A
`define OSS_DEV_RST_KEY 8'h5A
`define OSS_DEV_LED_ADDR 7'h22
`endif

// File: hw/oss_pkg.sv
// types shared by the serial port controller
package oss_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SEL = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_SRAD = 4'b0011,
    ST_DATA = 4'b0100,
    ST_HOLD = 4'b0101,
    ST_GAP = 4'b0110,
    ST_RST = 4'b0111,
    ST_WAKE = 4'b1000
  } oss_state_t;
endpackage

// File: hw/oss_byte_xfer.sv
// one byte on the three-wire link, msb first, clock idle high
`timescale 1ns/1ps
`include "oss_cfg.svh"
module oss_byte_xfer #(
  parameter int HALF = `OSS_SCK_HALF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic drive,
  input wire logic [7:0] tx,
  input wire logic sdi,
  output logic busy,
  output logic sck,
  output logic sdo,
  output logic oe,
  output logic [7:0] rx,
  output logic done
);
  import oss_pkg::*;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  logic [CW-1:0] cnt;
  logic high;
  logic [2:0] bitn;
  logic [7:0] sh;
  logic phase_end;
  logic last_bit;

  // synchronised input lags two cycles, so the high phase needs some room
  if (HALF < 4) begin : g_chk
    $error("oss_byte_xfer: HALF must be at least 4");
  end

  assign phase_end = busy && (cnt == CW'(HALF - 1));
  assign last_bit = (bitn == 3'h7);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt <= '0;
      high <= 1'b0;
      bitn <= 3'h0;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        cnt <= '0;
        high <= 1'b0;
        bitn <= 3'h0;
      end
    end else if (phase_end) begin
      cnt <= '0;
      if (!high) begin
        high <= 1'b1;
      end else if (last_bit) begin
        busy <= 1'b0;
      end else begin
        high <= 1'b0;
        bitn <= bitn + 3'h1;
      end
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  // falling edge launches a bit, the clock rests high after the last one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck <= 1'b1;
    end else if (!busy && start) begin
      sck <= 1'b0;
    end else if (phase_end) begin
      sck <= !high || last_bit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh <= 8'h00;
      sdo <= 1'b0;
      oe <= 1'b0;
    end else if (!busy && start) begin
      sh <= tx;
      sdo <= tx[7];
      oe <= drive;
    end else if (phase_end && high) begin
      if (last_bit) begin
        oe <= 1'b0;
      end else begin
        sh <= {sh[6:0], 1'b0};
        sdo <= sh[6];
      end
    end
  end

  // sample at the end of the high phase: the far end holds until our next fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx <= 8'h00;
      done <= 1'b0;
    end else begin
      if (phase_end && high) begin
        rx <= {rx[6:0], sdi};
      end
      done <= phase_end && high && last_bit;
    end
  end
endmodule

// File: hw/oss_host.sv
// ahb-lite controlled master for the optical sensor three-wire port
// Contract
// - Only the master starts exchanges; the sensor only answers master clocking.
// - After an abort the master still keeps the usual delays.
// - Master asserts select only around transactions, high when idle.
// - Write: address byte with msb one, then data byte, sampled on rising clock.
// - Read: address byte msb zero, then sensor drives data on falling edges.
// - Between writes, delay second write's last data rise by write_write_gap.
// - After a write, delay read's last address rise by write_read_gap.
// - In a read, wait read_address_data_delay after address before data clocking.
// - After a read, next command's first fall waits read_next_gap.
// - Master may end a burst at any byte boundary after the first.
// - Burst data bits run back to back at normal rate after the delay.
// - After a burst select stays high burst_exit_gap; port unusable until then.
// - Power-down ends only by full reset; then wait wakeup_wait and reload.
// - Master leaves the port alone and select high during power-down; the code still lowers select for the reset-key write to 0x3A then.
// - write_read_gap is at least 20 us between the two rising edges.
// - read_address_data_delay lies between 4 and 10 us.
// - read_next_gap is at least 500 ns.
// - burst_exit_gap is at least 250 ns of select high.
`timescale 1ns/1ps
`include "oss_cfg.svh"
module oss_host #(
  parameter int WAKEUP_CYC = `OSS_WAKEUP_CYC,
  parameter int SCK_HALF = `OSS_SCK_HALF,
  parameter int BURST_LEN = `OSS_BURST_LEN
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic serial_clock,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic serial_data_in,
  output logic port_select_n,
  output logic hard_reset_n,
  output oss_pkg::oss_state_t ctrl_state
);
  import oss_pkg::*;
  localparam int SEL_CYC = `OSS_CYC_MIN(`OSS_T_SEL_SCK_NS);
  localparam int SRAD_CYC = `OSS_CYC_MIN(`OSS_T_SRAD_MIN_NS);
  localparam int SRAD_MAX_CYC = `OSS_CYC_MAX(`OSS_T_SRAD_MAX_NS);
  localparam int HOLD_RD_CYC = `OSS_CYC_MIN(`OSS_T_SCK_SEL_RD_NS);
  localparam int HOLD_WR_CYC = `OSS_CYC_MIN(`OSS_T_SCK_SEL_WR_NS);
  localparam int WR_GAP_CYC = `OSS_CYC_MIN(`OSS_T_WR_GAP_NS);
  localparam int WW_GAP_CYC = `OSS_CYC_MIN(`OSS_T_WW_GAP_NS);
  localparam int RD_GAP_CYC = `OSS_CYC_MIN(`OSS_T_RD_GAP_NS);
  localparam int BEXIT_CYC = `OSS_CYC_MIN(`OSS_T_BEXIT_NS);
  localparam int HRST_CYC = `OSS_CYC_MIN(`OSS_T_HRST_NS);
  localparam int WGAP_CYC = (WR_GAP_CYC > WW_GAP_CYC) ? WR_GAP_CYC : WW_GAP_CYC;
  localparam int BGAP_CYC = (BEXIT_CYC > RD_GAP_CYC) ? BEXIT_CYC : RD_GAP_CYC;

  if (WAKEUP_CYC < 1 || BURST_LEN < 1 || BURST_LEN > `OSS_BURST_LEN) begin : g_chk
    $error("oss_host: WAKEUP_CYC or BURST_LEN out of range");
  end

  oss_state_t st;
  logic [31:0] wait_cnt;
  logic wait_zero;
  logic ap_we;
  logic [11:0] ap_addr;
  logic cmd_we;
  logic cmd_ok;
  logic [`OSS_CMD_W-1:0] cmd_word;
  logic [6:0] c_addr;
  logic c_wr;
  logic [7:0] c_data;
  logic c_burst;
  logic [2:0] c_last;
  logic c_rst_cmd;
  logic pd;
  logic [2:0] idx;
  logic [7:0] rbuf [0:`OSS_BURST_LEN-1];
  logic sdi_meta;
  logic sdi_sync;
  logic xfer_start;
  logic xfer_drive;
  logic [7:0] xfer_tx;
  logic xfer_busy;
  logic xfer_done;
  logic [7:0] xfer_rx;
  logic more_bytes;
  logic [31:0] status_word;
  logic [2:0] blen_w;

  assign wait_zero = (wait_cnt == 32'h0000_0000);
  assign ctrl_state = st;
  assign more_bytes = c_burst && (idx != c_last);

  // two flops before anything looks at the shared data line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      sdi_meta <= serial_data_in;
      sdi_sync <= sdi_meta;
    end
  end

  // zero-wait slave: address phase latched, read data prepared for data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we <= 1'b0;
      ap_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_we <= hsel && htrans[1] && hwrite && hready;
      if (hsel && htrans[1] && hready) begin
        ap_addr <= haddr[11:0];
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`OSS_ST_BUSY] = (st != ST_IDLE);
    status_word[`OSS_ST_PD] = pd;
    status_word[`OSS_ST_WAKE] = (st == ST_WAKE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr[11:0])
        `OSS_OFF_CMD: hrdata <= {{(32-`OSS_CMD_W){1'b0}}, cmd_word};
        `OSS_OFF_STATUS: hrdata <= status_word;
        `OSS_OFF_RDATA0: hrdata <= {rbuf[3], rbuf[2], rbuf[1], rbuf[0]};
        `OSS_OFF_RDATA1: hrdata <= {8'h00, rbuf[6], rbuf[5], rbuf[4]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // commands are taken only when idle; in power-down only a reset gets through
  assign cmd_we = ap_we && (ap_addr == `OSS_OFF_CMD);
  assign cmd_ok = cmd_we && (st == ST_IDLE) && (!pd || hwdata[`OSS_CMD_HRST] ||
    (hwdata[`OSS_CMD_WR] && !hwdata[`OSS_CMD_BURST] &&
     hwdata[`OSS_CMD_ADDR_MSB:`OSS_CMD_ADDR_LSB] == `OSS_DEV_RST_ADDR &&
     hwdata[`OSS_CMD_DATA_MSB:`OSS_CMD_DATA_LSB] == `OSS_DEV_RST_KEY));
  assign blen_w = hwdata[`OSS_CMD_BLEN_MSB:`OSS_CMD_BLEN_LSB];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_word <= '0;
      c_addr <= 7'h00;
      c_wr <= 1'b0;
      c_data <= 8'h00;
      c_burst <= 1'b0;
      c_last <= 3'h0;
      c_rst_cmd <= 1'b0;
    end else if (cmd_ok) begin
      cmd_word <= hwdata[`OSS_CMD_W-1:0];
      c_burst <= hwdata[`OSS_CMD_BURST];
      c_data <= hwdata[`OSS_CMD_DATA_MSB:`OSS_CMD_DATA_LSB];
      c_rst_cmd <= hwdata[`OSS_CMD_WR] && !hwdata[`OSS_CMD_BURST] &&
        hwdata[`OSS_CMD_ADDR_MSB:`OSS_CMD_ADDR_LSB] == `OSS_DEV_RST_ADDR &&
        hwdata[`OSS_CMD_DATA_MSB:`OSS_CMD_DATA_LSB] == `OSS_DEV_RST_KEY;
      if (hwdata[`OSS_CMD_BURST]) begin
        c_addr <= `OSS_DEV_BURST_ADDR;
        c_wr <= 1'b0;
        // zero or oversize length means the whole set
        if (blen_w == 3'h0 || 32'(blen_w) > BURST_LEN) begin
          c_last <= 3'(BURST_LEN - 1);
        end else begin
          c_last <= blen_w - 3'h1;
        end
      end else begin
        c_addr <= hwdata[`OSS_CMD_ADDR_MSB:`OSS_CMD_ADDR_LSB];
        c_wr <= hwdata[`OSS_CMD_WR];
        c_last <= 3'h0;
      end
    end
  end

  always_comb begin
    xfer_start = 1'b0;
    xfer_drive = 1'b1;
    xfer_tx = {c_wr, c_addr};
    case (st)
      ST_SEL: xfer_start = wait_zero;
      ST_ADDR: begin
        xfer_start = xfer_done && c_wr;
        xfer_tx = c_data;
      end
      ST_SRAD: begin
        xfer_start = wait_zero;
        xfer_drive = 1'b0;
      end
      ST_DATA: begin
        xfer_start = xfer_done && more_bytes;
        xfer_drive = 1'b0;
      end
      default: xfer_start = 1'b0;
    endcase
  end

  // sequencing; every wait is counted down to zero in wait_cnt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_IDLE;
      wait_cnt <= 32'h0000_0000;
      idx <= 3'h0;
    end else begin
      case (st)
        ST_IDLE: begin
          idx <= 3'h0;
          if (cmd_ok && hwdata[`OSS_CMD_HRST]) begin
            st <= ST_RST;
            wait_cnt <= 32'(HRST_CYC - 1);
          end else if (cmd_ok) begin
            st <= ST_SEL;
            wait_cnt <= 32'(SEL_CYC - 1);
          end
        end
        ST_SEL: begin
          if (wait_zero) begin
            st <= ST_ADDR;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_ADDR: begin
          if (xfer_done && c_wr) begin
            st <= ST_DATA;
          end else if (xfer_done) begin
            st <= ST_SRAD;
            wait_cnt <= 32'(SRAD_CYC - 1);
          end
        end
        ST_SRAD: begin
          if (wait_zero) begin
            st <= ST_DATA;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_DATA: begin
          if (xfer_done && more_bytes) begin
            idx <= idx + 3'h1;
          end else if (xfer_done) begin
            st <= ST_HOLD;
            wait_cnt <= c_wr ? 32'(HOLD_WR_CYC - 1) : 32'(HOLD_RD_CYC - 1);
          end
        end
        ST_HOLD: begin
          if (wait_zero) begin
            st <= ST_GAP;
            if (c_wr) begin
              wait_cnt <= 32'(WGAP_CYC - 1);
            end else if (c_burst) begin
              wait_cnt <= 32'(BGAP_CYC - 1);
            end else begin
              wait_cnt <= 32'(RD_GAP_CYC - 1);
            end
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_GAP: begin
          if (wait_zero && c_rst_cmd) begin
            st <= ST_WAKE;
            wait_cnt <= 32'(WAKEUP_CYC - 1);
          end else if (wait_zero) begin
            st <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_RST: begin
          if (wait_zero) begin
            st <= ST_WAKE;
            wait_cnt <= 32'(WAKEUP_CYC - 1);
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_WAKE: begin
          if (wait_zero) begin
            st <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // select framed tightly around each transaction; never left low when idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_select_n <= 1'b1;
    end else if (st == ST_IDLE && cmd_ok && !hwdata[`OSS_CMD_HRST]) begin
      port_select_n <= 1'b0;
    end else if (st == ST_HOLD && wait_zero) begin
      port_select_n <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hard_reset_n <= 1'b1;
    end else if (st == ST_IDLE && cmd_ok && hwdata[`OSS_CMD_HRST]) begin
      hard_reset_n <= 1'b0;
    end else if (st == ST_RST && wait_zero) begin
      hard_reset_n <= 1'b1;
    end
  end

  // power-down is tracked from what we wrote; only a full reset clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd <= 1'b0;
    end else if (st == ST_WAKE) begin
      pd <= 1'b0;
    end else if (st == ST_HOLD && wait_zero && c_wr && c_addr == `OSS_DEV_CTRL_ADDR) begin
      pd <= c_data[`OSS_DEV_PD_BIT];
    end
  end

  for (genvar gi = 0; gi < `OSS_BURST_LEN; gi++) begin : g_rbuf
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rbuf[gi] <= 8'h00;
      end else if (st == ST_DATA && xfer_done && !c_wr && idx == 3'(gi)) begin
        rbuf[gi] <= xfer_rx;
      end
    end
  end

  oss_byte_xfer #(.HALF(SCK_HALF)) u_xfer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(xfer_start),
    .drive(xfer_drive),
    .tx(xfer_tx),
    .sdi(sdi_sync),
    .busy(xfer_busy),
    .sck(serial_clock),
    .sdo(serial_data_out),
    .oe(serial_data_oe),
    .rx(xfer_rx),
    .done(xfer_done)
  );

  // helper counters watched only by the checks below
  logic [15:0] sck_high_run;
  logic [15:0] ncs_high_run;
  logic prev_wr;
  logic prev_burst;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_high_run <= 16'h0000;
      ncs_high_run <= 16'hFFFF;
      prev_wr <= 1'b0;
      prev_burst <= 1'b0;
    end else begin
      sck_high_run <= (serial_clock && !port_select_n) ? sck_high_run + 16'h1 : 16'h0000;
      if (!port_select_n) begin
        ncs_high_run <= 16'h0000;
      end else if (ncs_high_run != 16'hFFFF) begin
        ncs_high_run <= ncs_high_run + 16'h1;
      end
      if (st == ST_HOLD && wait_zero) begin
        prev_wr <= c_wr;
        prev_burst <= c_burst;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_sck_idle_high: assert property (port_select_n |-> serial_clock)
    else $error("serial clock low while deselected");
  a_oe_selected: assert property (serial_data_oe |-> !port_select_n)
    else $error("data line driven while deselected");
  a_msb_first: assert property ($rose(xfer_busy) && st == ST_ADDR |->
    serial_data_out == c_wr && !serial_clock) else $error("direction bit not first");
  a_read_release: assert property (st == ST_DATA && !c_wr && xfer_busy |->
    !serial_data_oe) else $error("master drives data byte of a read");
  a_write_drive: assert property (st == ST_DATA && c_wr && xfer_busy |->
    serial_data_oe) else $error("master not driving write data");
  a_srad_delay: assert property ($rose(xfer_busy) && st == ST_DATA && !c_wr &&
    idx == 3'h0 |-> sck_high_run >= SRAD_CYC && sck_high_run <= SRAD_MAX_CYC)
    else $error("address to data delay out of range");
  a_burst_btb: assert property (st == ST_DATA && xfer_done && more_bytes |=>
    xfer_busy ##1 !serial_clock) else $error("burst byte not back to back");
  a_read_gap: assert property ($fell(port_select_n) && !prev_wr |->
    ncs_high_run >= (prev_burst ? BGAP_CYC : RD_GAP_CYC))
    else $error("gap after read too short");
  a_write_gap: assert property ($fell(port_select_n) && prev_wr |->
    ncs_high_run >= WGAP_CYC) else $error("gap after write too short");
  a_pd_quiet: assert property (pd && !c_rst_cmd |-> port_select_n)
    else $error("port used during power-down");
  a_wake_after_reset: assert property ($rose(hard_reset_n) |-> st == ST_WAKE)
    else $error("no wakeup wait after hard reset");

  c_write_done: cover property (st == ST_DATA && xfer_done && c_wr);
  c_read_done: cover property (st == ST_DATA && xfer_done && !c_wr && !c_burst);
  c_full_burst: cover property (st == ST_DATA && xfer_done && c_burst && idx == 3'h6);
  c_wakeup: cover property (st == ST_WAKE && wait_zero);
endmodule

// File: tb/oss_sensor.sv
// behavioural sensor on the far side of the three-wire port
`timescale 1ns/1ps
module oss_sensor (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic rst_n,
  input wire logic din,
  output logic dout,
  output logic doe,
  output int viol
);
  logic [7:0] regs [0:127];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [6:0] a;
  logic rd;
  logic bst;
  int nb;
  int idx;
  realtime t_wr;
  realtime t_ad;
  realtime t_up;
  realtime t_rd;
  task automatic clr();
    for (int i = 0; i < 128; i++) regs[i] = (i >= 3 && i <= 9) ? 8'hA0 + 8'(i) : 8'h00;
  endtask
  initial begin
    clr();
    viol = 0;
    doe = 0;
    dout = 0;
    nb = 0;
    rd = 0;
    bst = 0;
    t_wr = -1e6;
    t_up = -1e6;
    t_rd = -1e6;
  end
  always @(negedge rst_n) clr();
  // released wire shows the inverse of its last level, not a held value
  always @(posedge sel_n) begin
    nb = 0;
    rd = 0;
    doe = 0;
    dout = ~dout;
    t_up = $realtime;
  end
  always @(negedge sel_n) begin
    if (bst && $realtime - t_up < 250) viol++;
    bst = 0;
  end
  always @(posedge sclk) if (!sel_n) begin
    if (nb < 8 || !rd) sh = {sh[6:0], din};
    nb++;
    if (nb == 8) begin
      a = sh[6:0];
      rd = !sh[7];
      if (rd) begin
        t_ad = $realtime;
        if (t_ad - t_wr < 20000) viol++;
        bst = (a == 7'h63);
        idx = bst ? 4 : 0;
        tx = bst ? regs[3] : regs[a];
      end
    end else if (nb == 16 && !rd) begin
      if (a == 7'h3A && sh == 8'h5A) clr();
      else regs[a] = sh;
      if ($realtime - t_wr < 20000) viol++;
      t_wr = $realtime;
    end else if (rd && nb > 8 && nb % 8 == 0 && bst && idx < 10) begin
      tx = regs[idx];
      idx++;
    end
    if (rd && nb > 8 && nb % 8 == 0) t_rd = $realtime;
  end
  // first fall of a new command must come late enough after the last read rise
  always @(negedge sclk) if (!sel_n && nb == 0 && $realtime - t_rd < 500) viol++;
  // drives only in answer to master clocking, holds until the next fall
  always @(negedge sclk) if (!sel_n && rd && nb >= 8) begin
    if (nb == 8 && ($realtime - t_ad < 4000 || $realtime - t_ad > 10000)) viol++;
    dout = tx[7];
    tx = {tx[6:0], 1'b0};
    doe = 1;
  end
endmodule

// File: tb/optical_sensor_serial_port_tb.sv
// bench for the serial port controller: bus tasks and command sequences
`timescale 1ns/1ps
module optical_sensor_serial_port_tb;
  import oss_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck, sdo, oe, sdi, psel_n, hrst_n, s_do, s_oe;
  oss_state_t st;
  int failures, total_checks, viol, clash;
  assign hready = hreadyout;
  assign sdi = oe ? sdo : s_do;
  // both ends driving the shared wire at once is a handoff fault
  always @(posedge hclk) if (oe && s_oe) clash++;
  oss_host #(.WAKEUP_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_clock(sck),
    .serial_data_out(sdo), .serial_data_oe(oe), .serial_data_in(sdi), .port_select_n(psel_n),
    .hard_reset_n(hrst_n), .ctrl_state(st));
  oss_sensor sen (.sclk(sck), .sel_n(psel_n), .rst_n(hrst_n), .din(sdi), .dout(s_do),
    .doe(s_oe), .viol(viol));
  always #5 hclk = ~hclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 200);
    q = hrdata;
    if (hready !== 1'b1) begin failures++; end_sim(); end
  endtask
  task automatic run(input logic [31:0] c);
    int n;
    ahb(1, 12'h000, c);
    n = 0;
    do begin ahb(0, 12'h004, 0); n++; end while (q[0] !== 1'b0 && n < 5000);
    do begin ahb(0, 12'h004, 0); n++; end while (q[2] !== 1'b0 && n < 5000);
    if (n >= 5000) begin failures++; end_sim(); end
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk({psel_n, sck, hrst_n, oe, hresp, hreadyout, 4'(st)}, 32'h390);
    run(32'h000001A2);
    chk({24'h0, sen.regs[7'h22]}, 32'h01);
    run(32'h00000022);
    ahb(0, 12'h008, 0);
    chk({24'h0, q[7:0]}, 32'h01);
    run(32'h00000005);
    ahb(0, 12'h008, 0);
    chk({24'h0, q[7:0]}, 32'h0A5);
    run(32'h000F0000);
    ahb(0, 12'h008, 0);
    chk(q, 32'hA6A5A4A3);
    ahb(0, 12'h00C, 0);
    chk(q, 32'h00A9A8A7);
    run(32'h00050000);
    ahb(0, 12'h008, 0);
    chk({16'h0, q[15:0]}, 32'hA4A3);
    ahb(0, 12'h010, 0);
    chk(q, 32'h0);
    run(32'h0000028D);
    chk({31'h0, q[1]}, 32'h1);
    ahb(1, 12'h000, 32'h00000003);
    ahb(0, 12'h004, 0);
    chk({30'h0, q[0], psel_n}, 32'h1);
    run(32'h00005ABA);
    chk({24'h0, sen.regs[7'h22]}, 32'h0);
    chk({31'h0, q[1]}, 32'h0);
    run(32'h000001A2);
    run(32'h00100000);
    chk({24'h0, sen.regs[7'h22]}, 32'h0);
    chk({29'h0, q[2:0]}, 32'h0);
    ahb(0, 12'h000, 0);
    chk(q, 32'h00100000);
    chk(32'(clash), 32'h0);
    chk(32'(viol), 32'h0);
    end_sim();
  end
endmodule
